// *** design/pwr_sup_cfg.svh ***
// offsets, field positions, reset values and timing counts of the supervisor
`ifndef PWR_SUP_CFG_SVH
`define PWR_SUP_CFG_SVH
// apb register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_CLEAR 8'h0C
`define REG_IRQ_ENABLE 8'h10
`define REG_IOUT 8'h14
// control fields and reset value
`define CTRL_TERM_EN 0
`define CTRL_ERR_EN 1
`define CTRL_RESET 2'h3
// interrupt event bits
`define IRQ_CS_SENT 0
`define IRQ_EPT_SENT 1
`define IRQ_OVP 2
`define IRQ_MODE 3
`define IRQ_FAST 4
`define IRQ_W 5
// timing: clock rate and packet periods in milliseconds
`define CLK_KHZ 32'h0000_C350
`define TICK_MS 32'h0000_0001
`define MID_FIRST_MS 32'h0002_BF20
`define MID_REPEAT_MS 32'h0002_BF20
`define LOW_FIRST_MS 32'h0000_1B58
`define LOW_REPEAT_MS 32'h0000_1B58
`define ERR_FAST_MS 8'h1E
`define ERR_SLOW_MS 8'hFA
// packet headers and payloads
`define HDR_CTRL_ERR 8'h03
`define HDR_EPT 8'h02
`define HDR_CS 8'h05
`define EPT_CHARGE_DONE 8'h01
`define CS_FULL 8'h64
// rectifier targets in millivolts, band limits in percent of max current
`define TGT_LIGHT 13'h1BA8
`define TGT_LOW 13'h1888
`define TGT_MID 13'h159A
`define TGT_HEAVY 13'h13F6
`define BAND_A 9'h00A
`define BAND_B 9'h014
`define BAND_C 9'h028
`define PCT_SCALE 24'h00_0064
// termination constants
`define TERM_K 16'h00C8
`define LOWER_DONE_MA 12'h028
`endif

// *** design/pwr_sup_pkg.sv ***
// types shared by the supervisor
package pwr_sup_pkg;
  // operating modes in pin order {mode_select_a, mode_select_b}
  typedef enum logic [1:0] {
    MODE_ADAPTER,
    MODE_WIRELESS,
    MODE_OTG,
    MODE_OFF
  } mode_t;
  // termination window the output current sits in
  typedef enum logic [1:0] {
    TW_NONE,
    TW_MID,
    TW_LOW
  } term_t;
endpackage

// *** design/wireless_rx_power_supervisor.sv ***
// digital supervisor of an inductive power receiver
`timescale 1ns/1ps
`default_nettype none
`include "pwr_sup_cfg.svh"

module wireless_rx_power_supervisor
  import pwr_sup_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `CLK_KHZ * `TICK_MS,
  parameter int unsigned MID_FIRST_MS = `MID_FIRST_MS,
  parameter int unsigned MID_REPEAT_MS = `MID_REPEAT_MS,
  parameter int unsigned LOW_FIRST_MS = `LOW_FIRST_MS,
  parameter int unsigned LOW_REPEAT_MS = `LOW_REPEAT_MS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous pins and analog comparators
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  input wire logic adapter_above_3v6,
  input wire logic vin_step,
  input wire logic rect_at_target,
  input wire logic ovp_hit,
  // measurements from the converter logic on pclk
  input wire logic [11:0] iout_ma,
  input wire logic [11:0] imax_ma,
  input wire logic [15:0] term_resistor_ohm,
  input wire logic [7:0] ctrl_err,
  // packet request to the modulator
  output logic pkt_valid,
  input wire logic pkt_ready,
  output logic [7:0] pkt_header,
  output logic [7:0] pkt_data,
  // power path control
  output logic [12:0] rectifier_target,
  output logic ldo_enable,
  output logic wired_gate_on,
  output logic wireless_enable,
  output logic comm_limit_enable,
  output logic otg_enable,
  // open-drain charge status and interrupt
  output logic charge_status_output_out,
  output logic charge_status_output_oe,
  output logic irq
);

  // true when i is below p percent of m
  function automatic logic below_pct(input logic [11:0] i, input logic [11:0] m,
                                     input logic [8:0] p);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = {12'h000, i} * `PCT_SCALE;
    rhs = {15'h0000, p} * {12'h000, m};
    return lhs < rhs;
  endfunction

  // pin synchronisers: only the second stage is read
  logic [5:0] meta_q;
  logic [5:0] pin_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 6'h00;
      pin_q <= 6'h00;
    end else begin
      meta_q <= {mode_select_a, mode_select_b, adapter_above_3v6, vin_step,
                 rect_at_target, ovp_hit};
      pin_q <= meta_q;
    end
  end

  logic sel_a, sel_b, adapter, step, at_target, ovp;
  assign sel_a = pin_q[5];
  assign sel_b = pin_q[4];
  assign adapter = pin_q[3];
  assign step = pin_q[2];
  assign at_target = pin_q[1];
  assign ovp = pin_q[0];

  // mode decode; floating selects are pulled low so reset value is adapter mode
  mode_t mode;
  assign mode = mode_t'({sel_a, sel_b});

  // previous samples for edge detection
  logic step_q, ovp_q;
  mode_t mode_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= 1'b0;
      ovp_q <= 1'b0;
      mode_q <= MODE_ADAPTER;
    end else begin
      step_q <= step;
      ovp_q <= ovp;
      mode_q <= mode;
    end
  end

  logic step_rise, ovp_rise, mode_chg, no_wireless;
  assign step_rise = step & ~step_q;
  assign ovp_rise = ovp & ~ovp_q;
  assign mode_chg = (mode != mode_q);
  assign no_wireless = (mode == MODE_OTG) || (mode == MODE_OFF);

  // apb-visible control
  logic [1:0] ctrl_q;
  logic [`IRQ_W-1:0] irq_sts_q;
  logic [`IRQ_W-1:0] irq_en_q;

  // power path selection
  logic wl_allow, wired_d;
  always_comb begin
    wl_allow = 1'b0;
    wired_d = 1'b0;
    case (mode)
      MODE_ADAPTER: begin
        wired_d = adapter;
        wl_allow = ~adapter;
      end
      MODE_WIRELESS: begin
        wl_allow = 1'b1;
      end
      MODE_OTG: begin
        wired_d = 1'b1;
      end
      default: begin
        wired_d = 1'b0;
      end
    endcase
  end

  // converged flag: the regulator waits for the first target hit
  logic conv_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q <= 1'b0;
    end else if (!wl_allow) begin
      conv_q <= 1'b0;
    end else if (at_target) begin
      conv_q <= 1'b1;
    end
  end

  // registered power path outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ldo_enable <= 1'b0;
      wired_gate_on <= 1'b0;
      wireless_enable <= 1'b0;
      comm_limit_enable <= 1'b0;
      otg_enable <= 1'b0;
    end else begin
      ldo_enable <= wl_allow & conv_q & ~ovp;
      wired_gate_on <= wired_d;
      wireless_enable <= wl_allow;
      comm_limit_enable <= (mode == MODE_ADAPTER);
      otg_enable <= (mode == MODE_OTG);
    end
  end

  // open-drain status: pulled low while the regulator is on
  assign charge_status_output_out = 1'b0;
  assign charge_status_output_oe = ldo_enable;

  // rectifier target; no-load target until the first convergence
  logic [12:0] tgt_d;
  always_comb begin
    if (!conv_q || below_pct(iout_ma, imax_ma, `BAND_A)) begin
      tgt_d = `TGT_LIGHT;
    end else if (below_pct(iout_ma, imax_ma, `BAND_B)) begin
      tgt_d = `TGT_LOW;
    end else if (below_pct(iout_ma, imax_ma, `BAND_C)) begin
      tgt_d = `TGT_MID;
    end else begin
      tgt_d = `TGT_HEAVY;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rectifier_target <= `TGT_LIGHT;
    end else begin
      rectifier_target <= tgt_d;
    end
  end

  // millisecond tick from the system clock
  logic [31:0] div_q;
  logic tick_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (div_q >= TICK_CYCLES - 1) begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // termination window; upper threshold percent is resistor over constant
  logic [15:0] upper_pct_w;
  logic [8:0] upper_pct;
  term_t win;
  assign upper_pct_w = term_resistor_ohm / `TERM_K;
  assign upper_pct = upper_pct_w[8:0];
  always_comb begin
    if (!ctrl_q[`CTRL_TERM_EN] || !ldo_enable) begin
      win = TW_NONE;
    end else if (iout_ma < `LOWER_DONE_MA) begin
      win = TW_LOW;
    end else if (below_pct(iout_ma, imax_ma, upper_pct)) begin
      win = TW_MID;
    end else begin
      win = TW_NONE;
    end
  end

  // deglitch and repeat timer of the termination window
  term_t term_q;
  logic first_q;
  logic [31:0] tcnt_q;
  logic [31:0] tlim;
  logic cs_fire_q;
  always_comb begin
    if (term_q == TW_LOW) begin
      tlim = first_q ? LOW_FIRST_MS : LOW_REPEAT_MS;
    end else begin
      tlim = first_q ? MID_FIRST_MS : MID_REPEAT_MS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_q <= TW_NONE;
      first_q <= 1'b1;
      tcnt_q <= 32'h0000_0000;
      cs_fire_q <= 1'b0;
    end else begin
      term_q <= win;
      cs_fire_q <= 1'b0;
      if (win != term_q) begin
        tcnt_q <= 32'h0000_0000;
        first_q <= 1'b1;
      end else if (tick_q && term_q != TW_NONE) begin
        if (tcnt_q >= tlim - 1) begin
          tcnt_q <= 32'h0000_0000;
          first_q <= 1'b0;
          cs_fire_q <= 1'b1;
        end else begin
          tcnt_q <= tcnt_q + 32'h0000_0001;
        end
      end
    end
  end

  // error packet pacing: fast after an input rise or overvoltage
  logic fast_q;
  logic [7:0] ecnt_q;
  logic [7:0] eper;
  logic err_fire_q;
  assign eper = fast_q ? `ERR_FAST_MS : `ERR_SLOW_MS;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_q <= 1'b0;
    end else if (step_rise || ovp) begin
      fast_q <= 1'b1;
    end else if (at_target) begin
      fast_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecnt_q <= 8'h00;
      err_fire_q <= 1'b0;
    end else begin
      err_fire_q <= 1'b0;
      if (tick_q) begin
        if (ecnt_q >= eper - 8'h01) begin
          ecnt_q <= 8'h00;
          err_fire_q <= 1'b1;
        end else begin
          ecnt_q <= ecnt_q + 8'h01;
        end
      end
    end
  end

  // pending packets; a new request wins over the load that clears it
  logic ept_pend_q, cs_pend_q, err_pend_q;
  logic load;
  logic ld_ept, ld_cs, ld_err;
  assign load = ~pkt_valid | pkt_ready;
  assign ld_ept = load & ept_pend_q;
  assign ld_cs = load & ~ept_pend_q & cs_pend_q;
  assign ld_err = load & ~ept_pend_q & ~cs_pend_q & err_pend_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ept_pend_q <= 1'b0;
      cs_pend_q <= 1'b0;
      err_pend_q <= 1'b0;
    end else begin
      if (ld_ept) begin
        ept_pend_q <= 1'b0;
      end
      if (no_wireless && (mode_chg || err_fire_q)) begin
        ept_pend_q <= 1'b1;
      end
      if (ld_cs) begin
        cs_pend_q <= 1'b0;
      end
      if (cs_fire_q) begin
        cs_pend_q <= 1'b1;
      end
      if (ld_err) begin
        err_pend_q <= 1'b0;
      end
      if (err_fire_q && !no_wireless && ctrl_q[`CTRL_ERR_EN]) begin
        err_pend_q <= 1'b1;
      end
    end
  end

  // packet output register, held until the modulator takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_valid <= 1'b0;
      pkt_header <= 8'h00;
      pkt_data <= 8'h00;
    end else if (load) begin
      pkt_valid <= ept_pend_q | cs_pend_q | err_pend_q;
      if (ept_pend_q) begin
        pkt_header <= `HDR_EPT;
        pkt_data <= `EPT_CHARGE_DONE;
      end else if (cs_pend_q) begin
        pkt_header <= `HDR_CS; // informative only, no end-power request
        pkt_data <= `CS_FULL;
      end else if (err_pend_q) begin
        pkt_header <= `HDR_CTRL_ERR;
        pkt_data <= ctrl_err;
      end
    end
  end

  // interrupt events
  logic [`IRQ_W-1:0] ev;
  assign ev = {step_rise, mode_chg, ovp_rise, ld_ept, ld_cs};

  // apb decode: zero wait states, error on unmapped offsets
  logic acc, wr, mapped;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign pready = 1'b1;
  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    if (paddr == `REG_CTRL) begin
      prdata = {30'h0000_0000, ctrl_q};
    end else if (paddr == `REG_STATUS) begin
      prdata = {3'h0, rectifier_target, 5'h00, term_q, mode, fast_q, conv_q,
                otg_enable, comm_limit_enable, wireless_enable,
                wired_gate_on, ldo_enable};
    end else if (paddr == `REG_IRQ_STATUS) begin
      prdata = {27'h000_0000, irq_sts_q};
    end else if (paddr == `REG_IRQ_CLEAR) begin
      prdata = 32'h0000_0000;
    end else if (paddr == `REG_IRQ_ENABLE) begin
      prdata = {27'h000_0000, irq_en_q};
    end else if (paddr == `REG_IOUT) begin
      prdata = {20'h0_0000, iout_ma};
    end else begin
      mapped = 1'b0;
    end
  end
  assign pslverr = acc & ~mapped;

  // control and enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      irq_en_q <= 5'h00;
    end else if (wr) begin
      if (paddr == `REG_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end else if (paddr == `REG_IRQ_ENABLE) begin
        irq_en_q <= pwdata[`IRQ_W-1:0];
      end
    end
  end

  // sticky status: a same-cycle event beats the write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= 5'h00;
    end else if (wr && paddr == `REG_IRQ_CLEAR) begin
      irq_sts_q <= (irq_sts_q & ~pwdata[`IRQ_W-1:0]) | ev;
    end else begin
      irq_sts_q <= irq_sts_q | ev;
    end
  end

  assign irq = |(irq_sts_q & irq_en_q);

endmodule // wireless_rx_power_supervisor
`default_nettype wire

// *** sim/sup_chk.sv ***
// port assertions for the receiver supervisor
`timescale 1ns/1ps
`default_nettype none
`include "pwr_sup_cfg.svh"
module sup_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  input wire logic adapter_above_3v6,
  input wire logic ovp_hit,
  input wire logic [7:0] ctrl_err,
  // packet port
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_header,
  input wire logic [7:0] pkt_data,
  // power path
  input wire logic [12:0] rectifier_target,
  input wire logic ldo_enable,
  input wire logic wired_gate_on,
  input wire logic wireless_enable,
  input wire logic comm_limit_enable,
  input wire logic otg_enable,
  input wire logic charge_status_output_out,
  input wire logic charge_status_output_oe
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // pins pass two sync stages and a register, so five held samples settle them
  adapter_off_a: assert property (
    (!mode_select_a && !mode_select_b && !adapter_above_3v6)[*5] |-> !wired_gate_on)
    else $error("wired gate on without adapter");
  adapter_on_a: assert property (
    (!mode_select_a && !mode_select_b && adapter_above_3v6)[*5]
    |-> wired_gate_on && !wireless_enable) else $error("adapter not given priority");
  wireless_only_a: assert property (
    (!mode_select_a && mode_select_b)[*5]
    |-> wireless_enable && !wired_gate_on && !comm_limit_enable) else $error("bad wireless mode");
  otg_mode_a: assert property (
    (mode_select_a && !mode_select_b)[*5]
    |-> wired_gate_on && otg_enable && !wireless_enable) else $error("bad otg mode");
  mode_off_a: assert property (
    (mode_select_a && mode_select_b)[*5]
    |-> !wired_gate_on && !wireless_enable && !ldo_enable) else $error("power in off mode");
  ovp_ldo_a: assert property (ovp_hit[*5] |-> !ldo_enable)
    else $error("regulator on in overvoltage");
  chg_pin_a: assert property (
    charge_status_output_oe == ldo_enable && !charge_status_output_out)
    else $error("charge status pin wrong");
  cs_payload_a: assert property (
    pkt_valid && pkt_header == `HDR_CS |-> pkt_data == `CS_FULL)
    else $error("full charge payload wrong");
  ept_reason_a: assert property (
    pkt_valid && pkt_header == `HDR_EPT |-> pkt_data == `EPT_CHARGE_DONE)
    else $error("end power reason wrong");
  err_payload_a: assert property (
    pkt_valid && pkt_header == `HDR_CTRL_ERR |-> pkt_data == ctrl_err)
    else $error("error packet payload wrong");
  target_set_a: assert property (
    rectifier_target inside {`TGT_LIGHT, `TGT_LOW, `TGT_MID, `TGT_HEAVY})
    else $error("rectifier target off table");
endmodule // sup_chk
bind wireless_rx_power_supervisor sup_chk chk (.pclk(pclk), .presetn(presetn),
  .mode_select_a(mode_select_a), .mode_select_b(mode_select_b),
  .adapter_above_3v6(adapter_above_3v6), .ovp_hit(ovp_hit), .ctrl_err(ctrl_err),
  .pkt_valid(pkt_valid), .pkt_header(pkt_header), .pkt_data(pkt_data),
  .rectifier_target(rectifier_target), .ldo_enable(ldo_enable),
  .wired_gate_on(wired_gate_on), .wireless_enable(wireless_enable),
  .comm_limit_enable(comm_limit_enable), .otg_enable(otg_enable),
  .charge_status_output_out(charge_status_output_out),
  .charge_status_output_oe(charge_status_output_oe));
`default_nettype wire

// *** sim/tx_pad_model.sv ***
// transmitter side model that accepts packets after a set lag
`timescale 1ns/1ps
`default_nettype none
module tx_pad_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // packet port
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_header,
  output logic pkt_ready,
  // observation
  input wire logic [3:0] lag,
  output logic got,
  output logic [7:0] last_hdr
);
  logic [3:0] wait_q;
  // ready drops after each take, so a slow pad never accepts two in a row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_ready <= 1'b0;
      wait_q <= 4'h0;
      got <= 1'b0;
      last_hdr <= 8'h00;
    end else begin
      got <= pkt_valid && pkt_ready;
      if (pkt_valid && pkt_ready) last_hdr <= pkt_header;
      wait_q <= (pkt_valid && !pkt_ready) ? wait_q + 4'h1 : 4'h0;
      pkt_ready <= pkt_valid && !pkt_ready && wait_q >= lag;
    end
  end
endmodule // tx_pad_model
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench of the receiver supervisor
`timescale 1ns/1ps
`default_nettype none
`include "pwr_sup_cfg.svh"
module testbench;
  // design and pad signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, ctrl_err, pkt_header, pkt_data, last_hdr;
  logic [31:0] pwdata, prdata, rd;
  logic mode_select_a, mode_select_b, adapter_above_3v6, vin_step, rect_at_target, ovp_hit;
  logic [11:0] iout_ma, imax_ma;
  logic [15:0] term_resistor_ohm;
  logic pkt_valid, pkt_ready, got, er;
  logic [12:0] rectifier_target;
  logic ldo_enable, wired_gate_on, wireless_enable, comm_limit_enable, otg_enable;
  logic charge_status_output_out, charge_status_output_oe;
  logic [3:0] lag;
  int failures, comparisons, n;
  // short counts: 50-cycle tick, 20 and 5 tick windows
  wireless_rx_power_supervisor #(.TICK_CYCLES(50), .MID_FIRST_MS(20), .MID_REPEAT_MS(20),
    .LOW_FIRST_MS(5), .LOW_REPEAT_MS(5)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_select_a(mode_select_a),
    .mode_select_b(mode_select_b), .adapter_above_3v6(adapter_above_3v6),
    .vin_step(vin_step), .rect_at_target(rect_at_target), .ovp_hit(ovp_hit),
    .iout_ma(iout_ma), .imax_ma(imax_ma), .term_resistor_ohm(term_resistor_ohm),
    .ctrl_err(ctrl_err), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .pkt_header(pkt_header), .pkt_data(pkt_data), .rectifier_target(rectifier_target),
    .ldo_enable(ldo_enable), .wired_gate_on(wired_gate_on),
    .wireless_enable(wireless_enable), .comm_limit_enable(comm_limit_enable),
    .otg_enable(otg_enable), .charge_status_output_out(charge_status_output_out),
    .charge_status_output_oe(charge_status_output_oe), .irq(irq));
  tx_pad_model pad (.pclk(pclk), .presetn(presetn), .pkt_valid(pkt_valid),
    .pkt_header(pkt_header), .pkt_ready(pkt_ready), .lag(lag), .got(got), .last_hdr(last_hdr));
  always #10 pclk = ~pclk;
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task in_range(input int v, input int lo, input int hi, input string m);
    chk(32'(v >= lo && v <= hi), 32'h0000_0001, m);
  endtask
  // apb master: setup, access until pready, then release
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // cycles until the pad takes a packet of header h, capped at lim
  task wait_pkt(input logic [7:0] h, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(got === 1'b1 && last_hdr === h) && n < lim);
  endtask
  task close_out;
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task t_regs;
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rd, `CTRL_RESET, "ctrl reset");
    apb(1'b0, `REG_IRQ_ENABLE, 32'h0);
    chk(rd, 32'h0, "irq enable reset");
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(rd[8:7], 2'b00, "default mode");
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    chk(er, 1'b1, "unmapped error");
    apb(1'b0, 8'h18, 32'h0);
    chk(er, 1'b1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    chk(pready, 1'b1, "zero wait ready");
  endtask
  // pins {a,b,adapter} and expected {gate,wireless,otg,limit}
  task t_modes;
    logic [2:0] pins [5];
    logic [3:0] ex [5];
    pins = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b110};
    ex = '{4'b0101, 4'b1001, 4'b0100, 4'b1010, 4'b0000};
    for (int i = 0; i < 5; i++) begin
      {mode_select_a, mode_select_b, adapter_above_3v6} <= pins[i];
      if (i < 3) repeat (8) @(posedge pclk);
      else wait_pkt(`HDR_EPT, 40);
      if (i >= 3) in_range(n, 1, 39, "end power on entry");
      chk({wired_gate_on, wireless_enable, otg_enable}, ex[i][3:1], "path");
      if (i < 3) chk(comm_limit_enable, ex[i][0], "comm limit");
    end
    {mode_select_a, mode_select_b, adapter_above_3v6} <= 3'b010;
  endtask
  task t_target;
    logic [11:0] cur [6];
    logic [12:0] tg [6];
    cur = '{12'h032, 12'h064, 12'h0C7, 12'h0C8, 12'h18F, 12'h190};
    tg = '{`TGT_LIGHT, `TGT_LOW, `TGT_LOW, `TGT_MID, `TGT_MID, `TGT_HEAVY};
    rect_at_target <= 1'b1;
    repeat (10) @(posedge pclk);
    chk({ldo_enable, charge_status_output_oe}, 2'b11, "regulator on");
    for (int i = 0; i < 6; i++) begin
      iout_ma <= cur[i];
      repeat (6) @(posedge pclk);
      chk(rectifier_target, tg[i], "target band");
    end
  endtask
  task t_low;
    lag <= 4'h3;
    iout_ma <= 12'h00A;
    wait_pkt(`HDR_CS, 400);
    in_range(n, 200, 262, "low first");
    wait_pkt(`HDR_CS, 400);
    in_range(n, 240, 262, "low repeat");
    lag <= 4'h0;
  endtask
  task t_irq;
    apb(1'b1, `REG_IRQ_CLEAR, 32'h0000_001F);
    apb(1'b1, `REG_IRQ_ENABLE, 32'h0000_0001);
    wait_pkt(`HDR_CS, 400);
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, `REG_IRQ_CLEAR, 32'h0000_0001);
    chk(irq, 1'b0, "irq cleared");
    apb(1'b1, `REG_IRQ_ENABLE, 32'h0);
    wait_pkt(`HDR_CS, 400);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    chk({irq, rd[0]}, 2'b01, "irq masked");
  endtask
  // short excursions out of the low window keep the first packet away
  task t_restart;
    for (int i = 0; i < 5; i++) begin
      wait_pkt(`HDR_CS, 200);
      chk(n, 200, "deglitch restart");
      iout_ma <= 12'h03C;
      @(posedge pclk);
      iout_ma <= 12'h00A;
    end
    wait_pkt(`HDR_CS, 300);
    in_range(n, 200, 262, "after restart");
  endtask
  task t_mid;
    iout_ma <= 12'h03C;
    wait_pkt(`HDR_CS, 1100);
    in_range(n, 940, 1012, "mid first");
    wait_pkt(`HDR_CS, 1100);
    in_range(n, 990, 1012, "mid repeat");
    iout_ma <= 12'h064;
    wait_pkt(`HDR_CS, 1500);
    chk(n, 1500, "upper edge");
  endtask
  task t_err;
    iout_ma <= 12'h1F4;
    rect_at_target <= 1'b0;
    vin_step <= 1'b1;
    wait_pkt(`HDR_CTRL_ERR, 1600);
    wait_pkt(`HDR_CTRL_ERR, 1600);
    in_range(n, 1490, 1512, "fast pacing");
    rect_at_target <= 1'b1;
    vin_step <= 1'b0;
    wait_pkt(`HDR_CTRL_ERR, 13000);
    wait_pkt(`HDR_CTRL_ERR, 13000);
    in_range(n, 12490, 12512, "slow pacing");
  endtask
  task t_ovp;
    ovp_hit <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({ldo_enable, charge_status_output_oe}, 2'b00, "ovp off");
    wait_pkt(`HDR_CTRL_ERR, 1600);
    wait_pkt(`HDR_CTRL_ERR, 1600);
    in_range(n, 1490, 1512, "ovp pacing");
    // error packets switched off in control: the next fast slot must stay quiet
    apb(1'b1, `REG_CTRL, 32'h0);
    wait_pkt(`HDR_CTRL_ERR, 1600);
    chk(n, 1600, "error packets off");
    ovp_hit <= 1'b0;
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, vin_step, rect_at_target, ovp_hit} = 8'h00;
    {mode_select_a, mode_select_b, adapter_above_3v6} = 3'b000;
    {paddr, pwdata, ctrl_err, lag} = {8'h00, 32'h0, 8'h12, 4'h0};
    {iout_ma, imax_ma, term_resistor_ohm} = {12'h1F4, 12'h3E8, 16'h07D0};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_modes;
    t_target;
    t_low;
    t_irq;
    t_restart;
    t_mid;
    t_err;
    t_ovp;
    close_out;
  end
  // hang guard, well past the longest run
  initial begin
    repeat (80000) @(posedge pclk);
    failures++;
    close_out;
  end
endmodule // testbench
`default_nettype wire
